// >>> design/swsc_top.sv
// Purpose: Watchdog pair and operating-state machine of a slave controller
// Assumes: 100 MHz clock, base tick is 4 clocks (40 ns)
// Notes: Register access is a plain synchronous read/write port
`timescale 1ns/1ps
`default_nettype none
`include "swsc_defines.svh"

module swsc_top #(
  parameter int OUT_W = 8
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [15:0] REG_RDATA_O,
  // Traffic monitors
  input wire logic BUS_PD_ACCESS_I,
  input wire logic LOCAL_ACCESS_I,
  // Configuration checks
  input wire logic MAILBOX_CFG_OK_I,
  input wire logic PD_CFG_OK_I,
  // State request
  input wire logic STATE_REQ_I,
  input wire logic [2:0] STATE_REQ_CODE_I,
  // Process data
  input wire logic [OUT_W-1:0] MASTER_OUT_DATA_I,
  input wire logic [OUT_W-1:0] SAFE_VALUE_I,
  output logic [OUT_W-1:0] PHYS_OUT_O,
  output logic INPUT_COPY_O,
  // Status
  output logic [2:0] STATE_O,
  output logic STATE_ACK_O,
  output logic MAILBOX_EN_O,
  output logic FILE_XFER_ONLY_O,
  output logic PD_EN_O,
  output logic BUS_WD_TRIG_O,
  output logic LOCAL_WD_TRIG_O
);

  // ==========================================
  // Registers
  logic [15:0] divider_q;
  logic [15:0] local_cnt_q;
  logic [15:0] bus_cnt_q;
  logic req_err_q;
  swsc_pkg::swsc_state_e state_q;

  wire sel_div = REG_ADDR_I == `SWSC_OFS_DIVIDER;
  wire sel_loc = REG_ADDR_I == `SWSC_OFS_LOCAL_WD;
  wire sel_bus = REG_ADDR_I == `SWSC_OFS_BUS_WD;

  // Values persist unless software writes them
  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      divider_q <= `SWSC_DIVIDER_RST;
      local_cnt_q <= `SWSC_LOCAL_WD_RST;
      bus_cnt_q <= `SWSC_BUS_WD_RST;
    end else if (REG_WR_I) begin
      if (sel_div) divider_q <= REG_WDATA_I;
      if (sel_loc) local_cnt_q <= REG_WDATA_I;
      if (sel_bus) bus_cnt_q <= REG_WDATA_I;
    end
  end

  // ==========================================
  // Register read path
  wire sel_state = REG_ADDR_I == `SWSC_OFS_STATE;
  wire sel_status = REG_ADDR_I == `SWSC_OFS_STATUS;
  // Status bits sit at their defined positions
  wire [15:0] status_w =
    (16'(BUS_WD_TRIG_O) << `SWSC_ST_BUS_TRIG) |
    (16'(LOCAL_WD_TRIG_O) << `SWSC_ST_LOCAL_TRIG) |
    (16'(req_err_q) << `SWSC_ST_REQ_ERR);
  logic [15:0] rdata_w;

  always_comb begin
    rdata_w = 16'h0000;
    if (sel_div) begin
      rdata_w = divider_q;
    end else if (sel_loc) begin
      rdata_w = local_cnt_q;
    end else if (sel_bus) begin
      rdata_w = bus_cnt_q;
    end else if (sel_state) begin
      rdata_w = {13'h0, state_q};
    end else if (sel_status) begin
      rdata_w = status_w;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) REG_RDATA_O <= 16'h0000;
    else if (REG_RD_I) REG_RDATA_O <= rdata_w;
  end

  // ==========================================
  // Base tick: 40 ns from 100 MHz clock
  logic [1:0] base_q;
  logic [15:0] tick_q;
  wire base_w = base_q == 2'(`SWSC_BASE_DIV - 1);
  // Watchdog tick after divider+2 base ticks
  // Tick phase runs free, so a first timeout may fall one tick short
  wire [16:0] tick_len_w = {1'b0, divider_q} + 17'h00001;
  wire wd_tick_w = base_w && ({1'b0, tick_q} >= tick_len_w);

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      base_q <= 2'h0;
      tick_q <= 16'h0000;
    end else begin
      base_q <= base_w ? 2'h0 : base_q + 2'h1;
      if (wd_tick_w) tick_q <= 16'h0000;
      else if (base_w) tick_q <= tick_q + 16'h0001;
    end
  end

  // ==========================================
  // Watchdog pair, one loop for both
  // Index 0 bus-side, index 1 local interface
  wire [1:0] wd_trig;
  wire [1:0] wd_kick = {LOCAL_ACCESS_I, BUS_PD_ACCESS_I};
  wire [15:0] wd_lim [2];
  assign wd_lim[0] = bus_cnt_q;
  assign wd_lim[1] = local_cnt_q;

  for (genvar i = 0; i < 2; i++) begin : g_wd
    logic [15:0] cnt_q;
    logic trig_q;
    // Zero count disables; trigger drops too
    wire off_w = wd_lim[i] == 16'h0000;
    wire exp_w = wd_tick_w && (cnt_q + 16'h0001 >= wd_lim[i]);
    // Access beats a same-cycle timeout: fresh traffic proves the link
    always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
        cnt_q <= 16'h0000;
        trig_q <= 1'b0;
      end else if (off_w) begin
        cnt_q <= 16'h0000;
        trig_q <= 1'b0;
      end else if (wd_kick[i]) begin
        // Access restarts the timeout and clears trigger
        cnt_q <= 16'h0000;
        trig_q <= 1'b0;
      end else if (exp_w) begin
        trig_q <= 1'b1;
      end else if (wd_tick_w && !trig_q) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
    assign wd_trig[i] = trig_q;
  end

  assign BUS_WD_TRIG_O = wd_trig[0];
  assign LOCAL_WD_TRIG_O = wd_trig[1];

  // ==========================================
  // Operating-state machine
  swsc_pkg::swsc_state_e state_d;
  logic ack_d;
  logic err_d;
  logic copy_d;
  // Refused request keeps the state; error stands until next request

  always_comb begin
    state_d = state_q;
    ack_d = 1'b0;
    err_d = req_err_q;
    copy_d = 1'b0;
    if (STATE_REQ_I) begin
      ack_d = 1'b1;
      err_d = 1'b0;
      case (state_q)
        swsc_pkg::ST_INIT: begin
          if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_CONFIGURATION)) begin
            if (MAILBOX_CFG_OK_I) begin
              state_d = swsc_pkg::ST_CONFIGURATION;
            end else begin
              err_d = 1'b1;
            end
          end else if (STATE_REQ_CODE_I ==
                       3'(swsc_pkg::ST_FIRMWARE_UPDATE)) begin
            if (MAILBOX_CFG_OK_I) begin
              state_d = swsc_pkg::ST_FIRMWARE_UPDATE;
            end else begin
              err_d = 1'b1;
            end
          end else if (STATE_REQ_CODE_I != 3'(swsc_pkg::ST_INIT)) begin
            err_d = 1'b1;
          end
        end
        swsc_pkg::ST_CONFIGURATION: begin
          if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_SAFE_OUTPUT)) begin
            // Inputs copied in the same cycle as the acknowledge
            if (PD_CFG_OK_I) begin
              state_d = swsc_pkg::ST_SAFE_OUTPUT;
              copy_d = 1'b1;
            end else err_d = 1'b1;
          end else if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_INIT)) begin
            state_d = swsc_pkg::ST_INIT;
          end else if (STATE_REQ_CODE_I !=
                       3'(swsc_pkg::ST_CONFIGURATION)) begin
            err_d = 1'b1;
          end
        end
        swsc_pkg::ST_SAFE_OUTPUT: begin
          if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_RUNNING)) begin
            state_d = swsc_pkg::ST_RUNNING;
          end else if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_INIT) ||
                       STATE_REQ_CODE_I ==
                       3'(swsc_pkg::ST_CONFIGURATION)) begin
            state_d = swsc_pkg::swsc_state_e'(STATE_REQ_CODE_I);
          end else if (STATE_REQ_CODE_I !=
                       3'(swsc_pkg::ST_SAFE_OUTPUT)) begin
            err_d = 1'b1;
          end
        end
        swsc_pkg::ST_RUNNING: begin
          if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_FIRMWARE_UPDATE) ||
              STATE_REQ_CODE_I > 3'(swsc_pkg::ST_FIRMWARE_UPDATE)) begin
            err_d = 1'b1;
          end else begin
            state_d = swsc_pkg::swsc_state_e'(STATE_REQ_CODE_I);
          end
        end
        default: begin
          if (STATE_REQ_CODE_I == 3'(swsc_pkg::ST_INIT)) begin
            state_d = swsc_pkg::ST_INIT;
          end else if (STATE_REQ_CODE_I !=
                       3'(swsc_pkg::ST_FIRMWARE_UPDATE)) begin
            err_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) begin
      state_q <= swsc_pkg::ST_INIT;
      req_err_q <= 1'b0;
      STATE_ACK_O <= 1'b0;
      INPUT_COPY_O <= 1'b0;
    end else begin
      state_q <= state_d;
      req_err_q <= err_d;
      STATE_ACK_O <= ack_d;
      INPUT_COPY_O <= copy_d;
    end
  end

  // ==========================================
  // Traffic permissions and outputs
  wire in_cfg = state_q == swsc_pkg::ST_CONFIGURATION;
  wire in_safe = state_q == swsc_pkg::ST_SAFE_OUTPUT;
  wire in_run = state_q == swsc_pkg::ST_RUNNING;
  wire in_fw = state_q == swsc_pkg::ST_FIRMWARE_UPDATE;

  assign STATE_O = 3'(state_q);
  assign MAILBOX_EN_O = in_cfg || in_safe || in_run || in_fw;
  assign FILE_XFER_ONLY_O = in_fw;
  assign PD_EN_O = in_safe || in_run;

  // ==========================================
  // Physical outputs
  // Bus watchdog forces safe values even in running; state is left alone
  wire apply_w = in_run && !wd_trig[0];

  always_ff @(posedge CLOCK_I) begin
    if (!RST_B_I) PHYS_OUT_O <= '0;
    else if (apply_w) PHYS_OUT_O <= MASTER_OUT_DATA_I;
    else PHYS_OUT_O <= SAFE_VALUE_I;
  end

endmodule
`default_nettype wire

// >>> design/swsc_defines.svh
// Purpose: Offsets, field positions and timing counts for the watchdog block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef SWSC_DEFINES_SVH
`define SWSC_DEFINES_SVH

// ==========================================
// Register offsets
`define SWSC_OFS_DIVIDER 12'h400
`define SWSC_OFS_LOCAL_WD 12'h410
`define SWSC_OFS_BUS_WD 12'h420
`define SWSC_OFS_STATE 12'h430
`define SWSC_OFS_STATUS 12'h434

// ==========================================
// Reset values
`define SWSC_DIVIDER_RST 16'h09C2
`define SWSC_BUS_WD_RST 16'h03E8
`define SWSC_LOCAL_WD_RST 16'h03E8

// ==========================================
// Timing
`define SWSC_CLK_MHZ 100
`define SWSC_BASE_MHZ 25
`define SWSC_BASE_DIV (`SWSC_CLK_MHZ / `SWSC_BASE_MHZ)

// ==========================================
// Status fields
`define SWSC_ST_BUS_TRIG 0
`define SWSC_ST_LOCAL_TRIG 1
`define SWSC_ST_REQ_ERR 2

`endif

// >>> design/swsc_pkg.sv
// Purpose: Types for the watchdog and state control block
// Assumes: Nothing
// Notes: Constants live in swsc_defines.svh
package swsc_pkg;

  // ==========================================
  // Slave states
  typedef enum logic [2:0] {
    ST_INIT,
    ST_CONFIGURATION,
    ST_SAFE_OUTPUT,
    ST_RUNNING,
    ST_FIRMWARE_UPDATE
  } swsc_state_e;

  // Requested state codes as written by the master
  typedef logic [2:0] swsc_req_t;

endpackage

// >>> sim/swsc_monitor.sv
// Purpose: Port checks for swsc_top
// Assumes: One clock domain, reset active low
// Notes: Bound to every swsc_top
`timescale 1ns/1ps
`default_nettype none
module swsc_monitor (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Inputs
  input wire logic BUS_PD_ACCESS_I,
  input wire logic MAILBOX_CFG_OK_I,
  input wire logic STATE_REQ_I,
  input wire logic [2:0] STATE_REQ_CODE_I,
  // Outputs
  input wire logic [2:0] STATE_O,
  input wire logic STATE_ACK_O,
  input wire logic INPUT_COPY_O,
  input wire logic MAILBOX_EN_O,
  input wire logic FILE_XFER_ONLY_O,
  input wire logic PD_EN_O,
  input wire logic BUS_WD_TRIG_O
);
  // ====
  // Properties
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  sequence s_cfg_req;
    STATE_REQ_I && STATE_REQ_CODE_I == 3'h1 && STATE_O == 3'h0;
  endsequence
  property p_ack; STATE_REQ_I |=> STATE_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_bad_cfg; s_cfg_req ##0 !MAILBOX_CFG_OK_I |=> STATE_O == 3'h0;
  endproperty
  a_bad_cfg: assert property (p_bad_cfg) else $error("bad cfg taken");
  property p_init; STATE_O == 3'h0 |-> !MAILBOX_EN_O && !PD_EN_O; endproperty
  a_init: assert property (p_init) else $error("init traffic");
  property p_cfg; STATE_O == 3'h1 |-> MAILBOX_EN_O && !PD_EN_O; endproperty
  a_cfg: assert property (p_cfg) else $error("cfg traffic");
  property p_safe; STATE_O == 3'h2 |-> MAILBOX_EN_O && PD_EN_O; endproperty
  a_safe: assert property (p_safe) else $error("safe traffic");
  property p_fw; STATE_O == 3'h4 |-> FILE_XFER_ONLY_O && !PD_EN_O; endproperty
  a_fw: assert property (p_fw) else $error("fw traffic");
  property p_fw_src; STATE_O == 3'h4 && $past(STATE_O) != 3'h4
    |-> $past(STATE_O) == 3'h0; endproperty
  a_fw_src: assert property (p_fw_src) else $error("fw entry");
  property p_copy; INPUT_COPY_O |-> STATE_ACK_O && STATE_O == 3'h2;
  endproperty
  a_copy: assert property (p_copy) else $error("copy misplaced");
  property p_clear; BUS_PD_ACCESS_I |=> !BUS_WD_TRIG_O; endproperty
  a_clear: assert property (p_clear) else $error("trig kept");
  property p_keep; !STATE_REQ_I |=> $stable(STATE_O); endproperty
  a_keep: assert property (p_keep) else $error("state moved");
endmodule
bind swsc_top swsc_monitor i_swsc_monitor (.CLOCK_I(CLOCK_I),
  .RST_B_I(RST_B_I), .BUS_PD_ACCESS_I(BUS_PD_ACCESS_I),
  .MAILBOX_CFG_OK_I(MAILBOX_CFG_OK_I), .STATE_REQ_I(STATE_REQ_I),
  .STATE_REQ_CODE_I(STATE_REQ_CODE_I), .STATE_O(STATE_O),
  .STATE_ACK_O(STATE_ACK_O), .INPUT_COPY_O(INPUT_COPY_O),
  .MAILBOX_EN_O(MAILBOX_EN_O), .FILE_XFER_ONLY_O(FILE_XFER_ONLY_O),
  .PD_EN_O(PD_EN_O), .BUS_WD_TRIG_O(BUS_WD_TRIG_O));
`default_nettype wire

// >>> sim/swsc_far_side.sv
// Purpose: Master and local processor model
// Assumes: Bench sets traffic and config
// Notes: Pulses every 4 clocks keep both watchdogs fed
`timescale 1ns/1ps
`default_nettype none
module swsc_far_side (
  // Clock
  input wire logic clk_i,
  // Bench controls
  input wire logic traffic_i,
  input wire logic cfg_done_i,
  // To the block
  output logic bus_acc_o = 1'b0,
  output logic local_acc_o = 1'b0,
  output logic mbx_ok_o,
  output logic pd_ok_o
);
  logic [1:0] cnt_q = 2'h0;
  // ====
  // Setup done by the master
  assign mbx_ok_o = cfg_done_i;
  assign pd_ok_o = cfg_done_i;
  // ====
  // Cyclic traffic, updated after the sampling edge by non-blocking writes
  always @(posedge clk_i) begin
    cnt_q <= cnt_q + 2'h1;
    bus_acc_o <= traffic_i && cnt_q == 2'h0;
    local_acc_o <= traffic_i && cnt_q == 2'h2;
  end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Purpose: Self-checking bench for swsc_top
// Assumes: Divider cut to 0 so a tick is 8 clocks
// Notes: Stimulus on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic req = 1'b0, traffic = 1'b0, cfg_done = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic [2:0] code = 3'h0;
  logic [7:0] mdata = 8'h3C, safe = 8'h5A;
  wire logic [15:0] rdata;
  wire logic [7:0] phys;
  wire logic [2:0] st;
  wire logic copy, ack, mbx, fx, pd, btrig, ltrig, bacc, lacc, mok, pok;
  int n_errors = 0, check_count = 0, cycles = 0;
  swsc_top i_swsc_top (.CLOCK_I(clk), .RST_B_I(rst_b), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .BUS_PD_ACCESS_I(bacc), .LOCAL_ACCESS_I(lacc),
    .MAILBOX_CFG_OK_I(mok), .PD_CFG_OK_I(pok), .STATE_REQ_I(req),
    .STATE_REQ_CODE_I(code), .MASTER_OUT_DATA_I(mdata),
    .SAFE_VALUE_I(safe), .PHYS_OUT_O(phys), .INPUT_COPY_O(copy),
    .STATE_O(st), .STATE_ACK_O(ack), .MAILBOX_EN_O(mbx),
    .FILE_XFER_ONLY_O(fx), .PD_EN_O(pd), .BUS_WD_TRIG_O(btrig),
    .LOCAL_WD_TRIG_O(ltrig));
  swsc_far_side i_swsc_far_side (.clk_i(clk), .traffic_i(traffic),
    .cfg_done_i(cfg_done), .bus_acc_o(bacc), .local_acc_o(lacc),
    .mbx_ok_o(mok), .pd_ok_o(pok));
  always #5 clk = ~clk;
  // ====
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a, input logic [15:0] e);
    @(negedge clk);
    addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rdata", rdata, e);
  endtask
  task automatic go(input logic [2:0] c, input logic [2:0] e);
    @(negedge clk);
    code = c;
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    chk("ack", 16'(ack), 16'h0001);
    chk("state", 16'(st), 16'(e));
  endtask
  // ====
  // Scenarios
  task automatic t_regs;
    rd_reg(12'h400, 16'h09C2);
    rd_reg(12'h410, 16'h03E8);
    rd_reg(12'h420, 16'h03E8);
    wr_reg(12'h40C, 16'hFFFF);
    rd_reg(12'h40C, 16'h0000);
    wr_reg(12'h420, 16'hFFFF);
    rd_reg(12'h420, 16'hFFFF);
    wr_reg(12'h400, 16'h0000);
    wr_reg(12'h410, 16'h0002);
    wr_reg(12'h420, 16'h0003);
    rd_reg(12'h400, 16'h0000);
    rd_reg(12'h410, 16'h0002);
    rd_reg(12'h420, 16'h0003);
    $display("t_regs done");
  endtask
  task automatic t_states;
    chk("init mbx", 16'(mbx), 16'h0000);
    go(3'h1, 3'h0);
    cfg_done = 1'b1;
    go(3'h1, 3'h1);
    chk("cfg pd", 16'(pd), 16'h0000);
    go(3'h4, 3'h1);
    traffic = 1'b1;
    go(3'h2, 3'h2);
    chk("copy", 16'(copy), 16'h0001);
    repeat (3) @(negedge clk);
    chk("safe out", 16'(phys), 16'(safe));
    go(3'h3, 3'h3);
    repeat (3) @(negedge clk);
    chk("run out", 16'(phys), 16'(mdata));
    $display("t_states done");
  endtask
  task automatic t_wd;
    repeat (40) @(negedge clk);
    chk("fed", 16'(btrig), 16'h0000);
    traffic = 1'b0;
    repeat (10) @(negedge clk);
    chk("early", 16'(btrig), 16'h0000);
    repeat (30) @(negedge clk);
    chk("bus trig", 16'(btrig), 16'h0001);
    chk("local trig", 16'(ltrig), 16'h0001);
    chk("forced", 16'(phys), 16'(safe));
    chk("kept", 16'(st), 16'h0003);
    rd_reg(12'h434, 16'h0003);
    rd_reg(12'h430, 16'h0003);
    traffic = 1'b1;
    repeat (8) @(negedge clk);
    chk("cleared", 16'(btrig), 16'h0000);
    wr_reg(12'h420, 16'h0000);
    rd_reg(12'h410, 16'h0002);
    traffic = 1'b0;
    repeat (50) @(negedge clk);
    chk("off", 16'(btrig), 16'h0000);
    chk("not forced", 16'(phys), 16'(mdata));
    $display("t_wd done");
  endtask
  task automatic t_fw;
    go(3'h0, 3'h0);
    go(3'h4, 3'h4);
    chk("fw only", 16'(fx), 16'h0001);
    go(3'h1, 3'h4);
    go(3'h7, 3'h4);
    rd_reg(12'h430, 16'h0004);
    rd_reg(12'h434, 16'h0006);
    go(3'h0, 3'h0);
    chk("init again", 16'(mbx), 16'h0000);
    $display("t_fw done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ====
  // Hang guard and main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_states();
    t_wd();
    t_fw();
    results();
  end
endmodule
`default_nettype wire
